//--- rtl/divcfg_pkg.sv
// Purpose: Shared constants and types for the output divider configuration bank
// Assumes: Byte-wide register port behind the serial interface, 16-bit addresses
// Notes:   Offsets are byte addresses of the serial register map
package divcfg_pkg;

  // ==========================================================================
  // Register map
  localparam logic [15:0] OUT0_INT_DIVIDE_ADDR        = 16'h003F;
  localparam logic [15:0] OUT1_INT_DIVIDE_ADDR        = 16'h0042;
  localparam logic [15:0] OUT2_INT_DIVIDE_ADDR        = 16'h0045;
  localparam logic [15:0] OUT3_INT_DIVIDE_TOP_ADDR    = 16'h0048;
  localparam logic [15:0] OUT3_INT_DIVIDE_MID_ADDR    = 16'h0049;
  localparam logic [15:0] OUT3_INT_DIVIDE_LOW_ADDR    = 16'h004A;
  localparam logic [15:0] OUT3_FRAC_DIVIDE_TOP_ADDR   = 16'h005F;
  localparam logic [15:0] OUT3_FRAC_DIVIDE_UPPER_ADDR = 16'h0060;
  localparam logic [15:0] OUT3_FRAC_DIVIDE_MID_ADDR   = 16'h0061;
  localparam logic [15:0] OUT3_FRAC_DIVIDE_LOW_ADDR   = 16'h0062;

  // ==========================================================================
  // Field layout and reset values
  localparam int          NUM_INT_OUTPUTS      = 3;
  localparam int          NUM_OUTPUTS          = 4;
  localparam int          INT3_WIDTH           = 18;
  localparam int          FRAC3_WIDTH          = 28;
  localparam int          BASE_WIDTH           = 19;
  localparam logic [7:0]  INT3_TOP_MASK        = 8'h03;
  localparam logic [7:0]  FRAC3_TOP_MASK       = 8'h0F;
  localparam logic [7:0]  FIRST_STAGE_RESET    = 8'h03;
  localparam logic [17:0] OUT3_INT_RESET       = 18'h20002;
  localparam logic [27:0] OUT3_FRAC_RESET      = 28'h0000000;
  localparam logic [7:0]  UNMAPPED_READ_VALUE  = 8'h00;

  // ==========================================================================
  // Register port request
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } reg_req_t;

endpackage

//--- rtl/out_divider.sv
// Purpose: One output divider counter with optional fractional accumulator
// Assumes: Source clock is the block clock; base_i is the integer period in cycles
// Notes:   Fractional step is in units of 2^-28 cycle; carries stretch a period
`timescale 1ns/1ps
`default_nettype none

module out_divider (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // Ratio
  input  wire logic        load_i,
  input  wire logic [18:0] base_i,
  input  wire logic [28:0] frac_step_i,
  // Divided clock
  output var  logic        div_clk_o
);

  logic [19:0] period_reg;
  logic [19:0] cnt_reg;
  logic [27:0] acc_reg;
  logic [29:0] sum;
  logic [19:0] base_eff;
  logic        wrap;
  logic [19:0] since_reg;

  // A zero base would never wrap; treat it as one cycle
  assign base_eff = (base_i == 19'h00000) ? 20'h00001 : {1'b0, base_i};
  assign sum      = {2'b00, acc_reg} + {1'b0, frac_step_i};
  assign wrap     = (cnt_reg >= period_reg - 20'h00001);

  // ==========================================================================
  // Period counter
  always_ff @(posedge clk_i) begin
    if (srst_i || load_i) begin
      cnt_reg <= 20'h00000;
    end else if (wrap) begin
      cnt_reg <= 20'h00000;
    end else begin
      cnt_reg <= cnt_reg + 20'h00001;
    end
  end

  // ==========================================================================
  // Period length and fractional accumulation
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      period_reg <= 20'h00001;
      acc_reg    <= 28'h0000000;
    end else if (load_i) begin
      period_reg <= base_eff;
      acc_reg    <= 28'h0000000;
    end else if (wrap) begin
      period_reg <= base_eff + {18'h00000, sum[29:28]};
      acc_reg    <= sum[27:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_clk_o <= 1'b0;
    end else begin
      div_clk_o <= (cnt_reg < {1'b0, period_reg[19:1]});
    end
  end

  // ==========================================================================
  // Checks
  always_ff @(posedge clk_i) begin
    if (srst_i || load_i || wrap) begin
      since_reg <= 20'h00000;
    end else begin
      since_reg <= since_reg + 20'h00001;
    end
  end

  property p_period_len;
    @(posedge clk_i) disable iff (srst_i)
      (wrap && !load_i && !$past(load_i)) |-> (since_reg == period_reg - 20'h00001);
  endproperty
  a_period_len: assert property (p_period_len) else $error("divider period length wrong");

  property p_load_pickup;
    @(posedge clk_i) disable iff (srst_i)
      load_i |=> (period_reg == $past(base_eff)) && (cnt_reg == 20'h00000);
  endproperty
  a_load_pickup: assert property (p_load_pickup) else $error("new ratio not picked up");

  property p_frac_stretch;
    @(posedge clk_i) disable iff (srst_i)
      (wrap && !load_i) |=> (period_reg - $past(base_eff) == {18'h00000, $past(sum[29:28])});
  endproperty
  a_frac_stretch: assert property (p_frac_stretch) else $error("fraction carry not applied");

endmodule

`default_nettype wire

//--- rtl/divcfg_regs.sv
// Purpose: Output divider ratio registers and the four output divider counters
// Assumes: Serial port logic presents one byte access per request on REG_REQ_I
// Notes:   Reserved bits are not stored and read back as zero
//
// Overview of operation
// - Outputs 0-2 first-stage ratio, 8 bits, reset 03h
// - Codes 03h to 06h divide by the code
// - Even codes 07h-A0h divide by code; odd unused
// - Output 3 integer field, 18 bits, reset 20002h
// - Output 3 integer ratio is twice field value
// - Output 3 fraction 28 bits at 005F to 0062
// - Output 3 integer bytes at 0048, 0049, 004A
// - First-stage fields at 003F, 0042, 0045
// - Fraction applied is twice field times 2^-28
`timescale 1ns/1ps
`default_nettype none

module divcfg_regs (
  // Clock and reset
  input  wire logic                 CLK_I,
  input  wire logic                 SRST_I,
  // Register port
  input  wire divcfg_pkg::reg_req_t REG_REQ_I,
  output var  logic [7:0]           RD_DATA_O,
  output var  logic                 RD_VALID_O,
  // Divided clocks
  output wire logic [3:0]           OUT_CLK_O
);

  logic [7:0]  int_div_reg [divcfg_pkg::NUM_INT_OUTPUTS];
  logic [17:0] out3_int_reg;
  logic [27:0] out3_frac_reg;
  logic [7:0]  rd_mux;
  logic [3:0]  load;
  logic [3:0]  load_reg;
  logic [18:0] base [divcfg_pkg::NUM_OUTPUTS];
  logic [28:0] frac_step [divcfg_pkg::NUM_OUTPUTS];
  logic        wr;
  logic [15:0] addr;
  logic [7:0]  wdata;

  localparam logic [15:0] INT_ADDR [divcfg_pkg::NUM_INT_OUTPUTS] = '{
    divcfg_pkg::OUT0_INT_DIVIDE_ADDR,
    divcfg_pkg::OUT1_INT_DIVIDE_ADDR,
    divcfg_pkg::OUT2_INT_DIVIDE_ADDR
  };

  assign wr    = REG_REQ_I.wr;
  assign addr  = REG_REQ_I.addr;
  assign wdata = REG_REQ_I.wdata;

  // ==========================================================================
  // First-stage integer ratio registers, outputs 0 to 2
  generate
    for (genvar i = 0; i < divcfg_pkg::NUM_INT_OUTPUTS; i++) begin : g_int
      always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
          int_div_reg[i] <= divcfg_pkg::FIRST_STAGE_RESET;
        end else if (wr && addr == INT_ADDR[i]) begin
          int_div_reg[i] <= wdata;
        end
      end
      assign load[i]      = wr && (addr == INT_ADDR[i]);
      assign base[i]      = {11'h000, int_div_reg[i]};
      assign frac_step[i] = 29'h00000000;
    end
  endgenerate

  // ==========================================================================
  // Output 3 integer portion
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      out3_int_reg <= divcfg_pkg::OUT3_INT_RESET;
    end else if (wr) begin
      case (addr)
        divcfg_pkg::OUT3_INT_DIVIDE_TOP_ADDR: begin
          out3_int_reg[17:16] <= wdata[1:0];
        end
        divcfg_pkg::OUT3_INT_DIVIDE_MID_ADDR: begin
          out3_int_reg[15:8] <= wdata;
        end
        divcfg_pkg::OUT3_INT_DIVIDE_LOW_ADDR: begin
          out3_int_reg[7:0] <= wdata;
        end
        default: begin
          out3_int_reg <= out3_int_reg;
        end
      endcase
    end
  end

  // ==========================================================================
  // Output 3 fractional portion
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      out3_frac_reg <= divcfg_pkg::OUT3_FRAC_RESET;
    end else if (wr) begin
      case (addr)
        divcfg_pkg::OUT3_FRAC_DIVIDE_TOP_ADDR: begin
          out3_frac_reg[27:24] <= wdata[3:0];
        end
        divcfg_pkg::OUT3_FRAC_DIVIDE_UPPER_ADDR: begin
          out3_frac_reg[23:16] <= wdata;
        end
        divcfg_pkg::OUT3_FRAC_DIVIDE_MID_ADDR: begin
          out3_frac_reg[15:8] <= wdata;
        end
        divcfg_pkg::OUT3_FRAC_DIVIDE_LOW_ADDR: begin
          out3_frac_reg[7:0] <= wdata;
        end
        default: begin
          out3_frac_reg <= out3_frac_reg;
        end
      endcase
    end
  end

  // Each byte write restarts the divider, so a multi-byte update passes
  // briefly through mixed ratios; write the low byte last
  assign load[3] = wr && (addr >= divcfg_pkg::OUT3_INT_DIVIDE_TOP_ADDR) &&
                   (addr <= divcfg_pkg::OUT3_INT_DIVIDE_LOW_ADDR ||
                    (addr >= divcfg_pkg::OUT3_FRAC_DIVIDE_TOP_ADDR &&
                     addr <= divcfg_pkg::OUT3_FRAC_DIVIDE_LOW_ADDR));
  assign base[3]      = {out3_int_reg, 1'b0};
  assign frac_step[3] = {out3_frac_reg, 1'b0};

  // Loads trail the write by one cycle, so a divider takes the value just
  // stored rather than the one it replaces
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      load_reg <= 4'h0;
    end else begin
      load_reg <= load;
    end
  end

  // ==========================================================================
  // Read path
  always_comb begin
    case (addr)
      divcfg_pkg::OUT0_INT_DIVIDE_ADDR:        rd_mux = int_div_reg[0];
      divcfg_pkg::OUT1_INT_DIVIDE_ADDR:        rd_mux = int_div_reg[1];
      divcfg_pkg::OUT2_INT_DIVIDE_ADDR:        rd_mux = int_div_reg[2];
      divcfg_pkg::OUT3_INT_DIVIDE_TOP_ADDR:    rd_mux = {6'h00, out3_int_reg[17:16]};
      divcfg_pkg::OUT3_INT_DIVIDE_MID_ADDR:    rd_mux = out3_int_reg[15:8];
      divcfg_pkg::OUT3_INT_DIVIDE_LOW_ADDR:    rd_mux = out3_int_reg[7:0];
      divcfg_pkg::OUT3_FRAC_DIVIDE_TOP_ADDR:   rd_mux = {4'h0, out3_frac_reg[27:24]};
      divcfg_pkg::OUT3_FRAC_DIVIDE_UPPER_ADDR: rd_mux = out3_frac_reg[23:16];
      divcfg_pkg::OUT3_FRAC_DIVIDE_MID_ADDR:   rd_mux = out3_frac_reg[15:8];
      divcfg_pkg::OUT3_FRAC_DIVIDE_LOW_ADDR:   rd_mux = out3_frac_reg[7:0];
      default:                                 rd_mux = divcfg_pkg::UNMAPPED_READ_VALUE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      RD_DATA_O <= 8'h00;
    end else if (REG_REQ_I.rd) begin
      RD_DATA_O <= rd_mux;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      RD_VALID_O <= 1'b0;
    end else begin
      RD_VALID_O <= REG_REQ_I.rd;
    end
  end

  // ==========================================================================
  // Divider counters
  generate
    for (genvar o = 0; o < divcfg_pkg::NUM_OUTPUTS; o++) begin : g_div
      out_divider u_div (
        .clk_i       (CLK_I),
        .srst_i      (SRST_I),
        .load_i      (load_reg[o]),
        .base_i      (base[o]),
        .frac_step_i (frac_step[o]),
        .div_clk_o   (OUT_CLK_O[o])
      );
    end
  endgenerate

  // ==========================================================================
  // Checks
  sequence s_wr_rd(logic [15:0] a);
    (REG_REQ_I.wr && REG_REQ_I.addr == a) ##1
    (REG_REQ_I.rd && !REG_REQ_I.wr && REG_REQ_I.addr == a);
  endsequence

  property p_reset_first_stage;
    @(posedge CLK_I) $fell(SRST_I) |->
      (int_div_reg[0] == 8'h03) && (int_div_reg[1] == 8'h03) && (int_div_reg[2] == 8'h03);
  endproperty
  a_reset_first_stage: assert property (p_reset_first_stage) else $error("first-stage reset bad");

  property p_reset_out3;
    // A write may land in the first free cycle, so both are checked at release
    @(posedge CLK_I) $fell(SRST_I) |-> (out3_int_reg == 18'h20002) && (base[3] == 19'h40004);
  endproperty
  a_reset_out3: assert property (p_reset_out3) else $error("out3 integer reset bad");

  property p_out0_rdback;
    @(posedge CLK_I) disable iff (SRST_I)
      s_wr_rd(16'h003F) |=> RD_VALID_O && (RD_DATA_O == $past(REG_REQ_I.wdata, 2));
  endproperty
  a_out0_rdback: assert property (p_out0_rdback) else $error("out0 ratio readback bad");

  property p_out3_top_rdback;
    @(posedge CLK_I) disable iff (SRST_I)
      s_wr_rd(16'h0048) |=> (RD_DATA_O == ($past(REG_REQ_I.wdata, 2) & 8'h03));
  endproperty
  a_out3_top_rdback: assert property (p_out3_top_rdback) else $error("out3 top readback bad");

  property p_frac_top_rdback;
    @(posedge CLK_I) disable iff (SRST_I)
      s_wr_rd(16'h005F) |=> (RD_DATA_O == ($past(REG_REQ_I.wdata, 2) & 8'h0F));
  endproperty
  a_frac_top_rdback: assert property (p_frac_top_rdback) else $error("frac top readback bad");

  property p_out3_double;
    @(posedge CLK_I) disable iff (SRST_I)
      (REG_REQ_I.wr && REG_REQ_I.addr == 16'h004A) |=>
        (base[3][8:1] == $past(REG_REQ_I.wdata)) && !base[3][0];
  endproperty
  a_out3_double: assert property (p_out3_double) else $error("out3 ratio not doubled");

  property p_even_code_base;
    @(posedge CLK_I) disable iff (SRST_I)
      (REG_REQ_I.wr && REG_REQ_I.addr == 16'h0042) |=> ##1
        (g_div[1].u_div.period_reg == {12'h000, $past(REG_REQ_I.wdata, 2)} ||
         $past(REG_REQ_I.wdata, 2) == 8'h00);
  endproperty
  a_even_code_base: assert property (p_even_code_base) else $error("out1 period not the code");

endmodule

`default_nettype wire

//--- bench/output_divider_config_regs_bench.sv
// Purpose: Self-checking bench for the divider ratio register bank
// Assumes: Byte register port, one access per request
// Notes:   Inputs move on the rising edge, outputs are sampled on the falling edge
`timescale 1ns/1ps
`default_nettype none

module output_divider_config_regs_bench;
  // ==========================================================================
  // Clock, reset and design
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  rst;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
  } row_t;

  logic                 clk_i     = 1'h0;
  logic                 srst_i    = 1'h1;
  divcfg_pkg::reg_req_t req       = '0;
  logic [7:0]           rd_data;
  logic                 rd_valid;
  logic [3:0]           out_clk;
  int                   err_total = 0;
  int                   compares  = 0;
  int                   per;
  int                   high;
  // Written values keep reserved bits at zero and ratios legal
  // Reserved bits reading zero is this block's own choice
  row_t                 rows [11] = '{
    '{16'h003F, 8'h03, 8'hA0, 8'hA0}, '{16'h0042, 8'h03, 8'h06, 8'h06},
    '{16'h0045, 8'h03, 8'h03, 8'h03}, '{16'h0048, 8'h02, 8'h03, 8'h03},
    '{16'h0049, 8'h00, 8'h12, 8'h12}, '{16'h004A, 8'h02, 8'h34, 8'h34},
    '{16'h005F, 8'h00, 8'h0F, 8'h0F}, '{16'h0060, 8'h00, 8'h56, 8'h56},
    '{16'h0061, 8'h00, 8'h78, 8'h78}, '{16'h0062, 8'h00, 8'h9A, 8'h9A},
    '{16'h0040, 8'h00, 8'h00, 8'h00}};

  always #5 clk_i = ~clk_i;

  divcfg_regs DUT (
    .CLK_I      (clk_i),
    .SRST_I     (srst_i),
    .REG_REQ_I  (req),
    .RD_DATA_O  (rd_data),
    .RD_VALID_O (rd_valid),
    .OUT_CLK_O  (out_clk)
  );

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic access(input logic [15:0] a, input logic w, input logic r, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{addr: a, wr: w, rd: r, wdata: d};
    @(posedge clk_i);
    req.wr <= 1'h0;
    req.rd <= 1'h0;
    @(negedge clk_i);
    check({31'h0, rd_valid}, {31'h0, r}, "read valid");
    @(negedge clk_i);
    check({31'h0, rd_valid}, 32'h0, "valid is one pulse");
  endtask

  // Write, then read the same byte on the very next cycle
  task automatic wr_then_rd(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{addr: a, wr: 1'h1, rd: 1'h0, wdata: d};
    @(posedge clk_i);
    req <= '{addr: a, wr: 1'h0, rd: 1'h1, wdata: 8'h00};
    @(posedge clk_i);
    req.rd <= 1'h0;
    @(negedge clk_i);
    check({24'h0, rd_data}, {24'h0, d}, "back-to-back readback");
  endtask

  // k consecutive full periods of output n, counted from a rising edge on;
  // consecutive, so fractional periods alternate inside one call
  task automatic measure(input int n, input int k, output int p, output int h);
    logic prev;
    int   t;
    p = 0;
    h = 0;
    repeat (3) @(negedge clk_i);
    for (t = 0; t < 400 && out_clk[n] !== 1'h0; t++) @(negedge clk_i);
    for (t = 0; t < 400 && out_clk[n] !== 1'h1; t++) @(negedge clk_i);
    for (t = 0; t < k; t++) begin
      do begin
        if (out_clk[n] === 1'h1) h++;
        prev = out_clk[n];
        p++;
        @(negedge clk_i);
      end while (p < 400 && !(prev === 1'h0 && out_clk[n] === 1'h1));
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    srst_i <= 1'h0;
    @(negedge clk_i);
    check({19'h0, rd_data, rd_valid, out_clk}, 32'h0, "outputs after reset");
    // Each row's bytes are distinct, so its reset value still stands when it is read
    foreach (rows[i]) begin
      access(rows[i].addr, 1'h0, 1'h1, 8'h00);
      check({24'h0, rd_data}, {24'h0, rows[i].rst}, "reset value");
      access(rows[i].addr, 1'h1, 1'h0, rows[i].wdata);
      access(rows[i].addr, 1'h0, 1'h1, 8'h00);
      check({24'h0, rd_data}, {24'h0, rows[i].rdata}, "readback");
    end
    // Write and read in one cycle: the read returns the value from before
    access(16'h0042, 1'h1, 1'h1, 8'h0A);
    check({24'h0, rd_data}, 32'h06, "read beside write");
    access(16'h0042, 1'h0, 1'h1, 8'h00);
    check({24'h0, rd_data}, 32'h0A, "write landed");
    // Read on the cycle right after the write
    wr_then_rd(16'h003F, 8'h0C);
    wr_then_rd(16'h0048, 8'h01);
    wr_then_rd(16'h005F, 8'h05);
    // First-stage ratios: low codes, even codes and the top code
    access(16'h0042, 1'h1, 1'h0, 8'h04);
    measure(1, 1, per, high);
    check(per, 4, "out1 period");
    check(high, 2, "out1 high time");
    access(16'h003F, 1'h1, 1'h0, 8'h08);
    measure(0, 1, per, high);
    check(per, 8, "out0 period");
    access(16'h0045, 1'h1, 1'h0, 8'hA0);
    measure(2, 1, per, high);
    check(per, 160, "out2 period");
    check(high, 80, "out2 high time");
    // Output 3: integer 3 doubles to 6, then a half fraction adds one every other period
    access(16'h0048, 1'h1, 1'h0, 8'h00);
    access(16'h0049, 1'h1, 1'h0, 8'h00);
    access(16'h005F, 1'h1, 1'h0, 8'h00);
    access(16'h0060, 1'h1, 1'h0, 8'h00);
    access(16'h0061, 1'h1, 1'h0, 8'h00);
    access(16'h0062, 1'h1, 1'h0, 8'h00);
    access(16'h004A, 1'h1, 1'h0, 8'h03);
    measure(3, 1, per, high);
    check(per, 6, "out3 integer period");
    check(high, 3, "out3 high time");
    access(16'h005F, 1'h1, 1'h0, 8'h04);
    measure(3, 2, per, high);
    check(per, 13, "out3 two fractional periods");
    check(high, 6, "out3 two fractional high times");
    // Reset in mid-run puts every ratio back
    @(posedge clk_i);
    srst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'h0;
    @(negedge clk_i);
    check({19'h0, rd_data, rd_valid, out_clk}, 32'h0, "outputs after second reset");
    access(16'h0042, 1'h0, 1'h1, 8'h00);
    check({24'h0, rd_data}, 32'h03, "out1 ratio after second reset");
    access(16'h004A, 1'h0, 1'h1, 8'h00);
    check({24'h0, rd_data}, 32'h02, "out3 low byte after second reset");
    access(16'h005F, 1'h0, 1'h1, 8'h00);
    check({24'h0, rd_data}, 32'h00, "out3 fraction after second reset");
    report_and_stop();
  end

  // ==========================================================================
  // Watchdog, sized well above the several hundred cycles the sequence needs
  initial begin
    #200us;
    err_total++;
    report_and_stop();
  end
endmodule

`default_nettype wire
